// [counter_array_capture_regs.sv]
// Register-access logic of the counter array: counter bytes with a high-byte snapshot,
// three module value registers, auto-reload bytes and comparator enable side effects.
// The count itself is not stored here: counter byte writes leave as strobes with data,
// because the counting logic outside owns the running value.
// Assumes the counting logic, mode registers and PWM configuration live outside and talk
// through the plain ports below; all inputs come from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module counter_array_capture_regs (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [15:0] array_counter,
    input  wire logic        watchdog_enable_bit,
    input  wire logic        auto_reload_select,
    input  wire logic [2:0]  pwm_wide_mode,
    output logic             counter_low_wr,
    output logic             counter_high_wr,
    output logic      [7:0]  counter_wdata,
    output logic      [47:0] module_capture_value,
    output logic      [47:0] auto_reload_value,
    output logic      [2:0]  comparator_enable
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // The module addresses are scattered over two ranges, so each pair is
    // looked up by module index instead of being computed from a base.
    function automatic logic [7:0] low_addr(input int idx);
        case (idx)
            0:       low_addr = counter_array_pkg::module0_low_addr;
            1:       low_addr = counter_array_pkg::module1_low_addr;
            default: low_addr = counter_array_pkg::module2_low_addr;
        endcase
    endfunction

    function automatic logic [7:0] high_addr(input int idx);
        case (idx)
            0:       high_addr = counter_array_pkg::module0_high_addr;
            1:       high_addr = counter_array_pkg::module1_high_addr;
            default: high_addr = counter_array_pkg::module2_high_addr;
        endcase
    endfunction

    // One byte of a 16-bit value, as seen at the low or the high address.
    function automatic logic [7:0] byte_of(input logic [15:0] value, input logic upper);
        byte_of = upper ? value[15:8] : value[7:0];
    endfunction

    // A 16-bit value with one byte replaced by written data; the other byte is kept.
    function automatic logic [15:0] merge_byte(
        input logic [15:0] value,
        input logic [7:0]  data,
        input logic        upper
    );
        merge_byte = upper ? {data, value[7:0]} : {value[15:8], data};
    endfunction

    wire logic hit_counter_low  = (sfr_addr == counter_array_pkg::counter_low_addr);
    wire logic hit_counter_high = (sfr_addr == counter_array_pkg::counter_high_addr);

    logic [7:0] snapshot_high;
    logic [2:0] hit_low;
    logic [2:0] hit_high;
    logic [2:0] hit_module;
    logic [2:0] reload_path;
    logic [7:0] module_read [3];

    // ------------------------------------------------------------
    // Counter snapshot
    // ------------------------------------------------------------
    // Latching on the low-byte read keeps a low-then-high read coherent even
    // when the counter carries from the low into the high byte between them.
    wire logic       read_counter_low = sfr_rd & hit_counter_low;
    wire logic [7:0] next_snapshot    =
        read_counter_low ? array_counter[15:8] : snapshot_high;

    always_ff @(posedge clk) begin
        if (srst) begin
            snapshot_high <= counter_array_pkg::byte_reset;
        end else begin
            snapshot_high <= next_snapshot;
        end
    end

    // ------------------------------------------------------------
    // Counter write strobes
    // ------------------------------------------------------------
    // A refused write raises no strobe (only the data copy still follows the bus), so the counting logic needs no
    // watchdog knowledge of its own.
    wire logic next_low_wr  =
        sfr_wr & hit_counter_low & ~watchdog_enable_bit;
    wire logic next_high_wr =
        sfr_wr & hit_counter_high & ~watchdog_enable_bit;

    always_ff @(posedge clk) begin
        if (srst) begin
            counter_low_wr <= 1'h0;
        end else begin
            counter_low_wr <= next_low_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            counter_high_wr <= 1'h0;
        end else begin
            counter_high_wr <= next_high_wr;
        end
    end

    // The data copy follows the bus every cycle; it only matters beside a strobe.
    always_ff @(posedge clk) begin
        if (srst) begin
            counter_wdata <= counter_array_pkg::byte_reset;
        end else begin
            counter_wdata <= sfr_wdata;
        end
    end

    // ------------------------------------------------------------
    // Capture/compare modules
    // ------------------------------------------------------------
    genvar m;
    generate
        for (m = 0; m < counter_array_pkg::num_modules; m++) begin : g_mod
            logic [15:0] stored_capture;
            logic [15:0] stored_reload;
            logic        stored_enable;

            // ----------------------------------------------------
            // Write side
            // ----------------------------------------------------
            assign hit_low[m]     = (sfr_addr == low_addr(m));
            assign hit_high[m]    = (sfr_addr == high_addr(m));
            assign hit_module[m]  = hit_low[m] | hit_high[m];
            // Any width from 9 to 16 bits counts as a wide PWM mode; in the 8-bit
            // mode the select bit is ignored and the compare value is reached.
            assign reload_path[m] = auto_reload_select & pwm_wide_mode[m];

            wire logic write_module  = sfr_wr & hit_module[m];
            wire logic write_capture = write_module & ~reload_path[m];
            wire logic write_reload  = write_module & reload_path[m];

            wire logic [15:0] next_capture =
                write_capture ? merge_byte(stored_capture, sfr_wdata, hit_high[m])
                              : stored_capture;
            wire logic [15:0] next_reload  =
                write_reload ? merge_byte(stored_reload, sfr_wdata, hit_high[m])
                             : stored_reload;
            // The enable follows the written address, whichever value the byte lands in;
            // the bit itself sits in the mode register outside, this block owns its value.
            wire logic next_enable = (sfr_wr & hit_high[m])
                | (stored_enable & ~(sfr_wr & hit_low[m]));

            always_ff @(posedge clk) begin
                if (srst) begin
                    stored_capture <= counter_array_pkg::value_reset;
                end else begin
                    stored_capture <= next_capture;
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    stored_reload <= counter_array_pkg::value_reset;
                end else begin
                    stored_reload <= next_reload;
                end
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    stored_enable <= 1'h0;
                end else begin
                    stored_enable <= next_enable;
                end
            end

            // ----------------------------------------------------
            // Read side
            // ----------------------------------------------------
            assign module_read[m] = reload_path[m] ? byte_of(stored_reload, hit_high[m])
                                                   : byte_of(stored_capture, hit_high[m]);

            // The outputs are plain copies of the flops above, with no logic between.
            assign module_capture_value[16*m +: 16] = stored_capture;
            assign auto_reload_value[16*m +: 16]    = stored_reload;
            assign comparator_enable[m]             = stored_enable;
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unmapped addresses read as zero, so a stray read never shows stale data.
    wire logic [7:0] next_rdata =
        hit_counter_low  ? array_counter[7:0] :
        hit_counter_high ? snapshot_high :
        hit_module[0]    ? module_read[0] :
        hit_module[1]    ? module_read[1] :
        hit_module[2]    ? module_read[2] :
        counter_array_pkg::byte_reset;

    // Read data stands until the next read, so software may pick it up late.
    always_ff @(posedge clk) begin
        if (srst) begin
            sfr_rdata <= counter_array_pkg::byte_reset;
        end else if (sfr_rd) begin
            sfr_rdata <= next_rdata;
        end
    end

endmodule

`default_nettype wire

// [counter_array_pkg.sv]
// Constants for the counter array register-access block.
// Assumes an 8-bit special-function-register bus on the system clock.
package counter_array_pkg;

    localparam int          num_modules         = 3;
    localparam int          data_width          = 8;
    localparam logic [7:0]  counter_low_addr    = 8'hf9;
    localparam logic [7:0]  counter_high_addr   = 8'hfa;
    localparam logic [7:0]  module0_low_addr    = 8'hfb;
    localparam logic [7:0]  module0_high_addr   = 8'hfc;
    localparam logic [7:0]  module1_low_addr    = 8'he9;
    localparam logic [7:0]  module1_high_addr   = 8'hea;
    localparam logic [7:0]  module2_low_addr    = 8'heb;
    localparam logic [7:0]  module2_high_addr   = 8'hec;
    localparam int          comparator_enable_bit = 6;
    localparam logic [7:0]  byte_reset          = 8'h00;
    localparam logic [15:0] value_reset         = 16'h0000;

endpackage

// [counter_array_capture_regs_monitor.sv]
// Port assertions for the counter array register block.
// Assumes it is bound onto counter_array_capture_regs.
`timescale 1ns/1ps
`default_nettype none
module counter_array_capture_regs_monitor (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic [15:0] array_counter,
    input wire logic        watchdog_enable_bit,
    input wire logic        auto_reload_select,
    input wire logic [2:0]  pwm_wide_mode,
    input wire logic        counter_low_wr,
    input wire logic        counter_high_wr,
    input wire logic [7:0]  counter_wdata,
    input wire logic [47:0] module_capture_value,
    input wire logic [47:0] auto_reload_value,
    input wire logic [2:0]  comparator_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire rl = sfr_rd && sfr_addr == counter_array_pkg::counter_low_addr;
    wire rh = sfr_rd && sfr_addr == counter_array_pkg::counter_high_addr;
    wire wl = sfr_wr && sfr_addr == counter_array_pkg::module0_low_addr;
    wire wh = sfr_wr && sfr_addr == counter_array_pkg::module0_high_addr;
    wire w2 = sfr_wr && sfr_addr == counter_array_pkg::module2_high_addr && auto_reload_select;
    wire wc = sfr_wr && sfr_addr == counter_array_pkg::counter_high_addr;
    low_read_a: assert property (rl |=> sfr_rdata == $past(array_counter[7:0]))
        else $error("low read");
    snap_read_a: assert property (rl ##1 !rl ##1 rh |=>
        sfr_rdata == $past(array_counter[15:8], 3)) else $error("snapshot");
    wd_block_a: assert property (sfr_wr && watchdog_enable_bit |=>
        !counter_low_wr && !counter_high_wr) else $error("not blocked");
    hi_write_a: assert property (wc && !watchdog_enable_bit |=>
        counter_high_wr && counter_wdata == $past(sfr_wdata)) else $error("high write");
    en_clear_a: assert property (wl |=> !comparator_enable[0])
        else $error("enable kept");
    en_set_a: assert property (wh |=> comparator_enable[0])
        else $error("enable unset");
    low_value_a: assert property (wl && !(auto_reload_select && pwm_wide_mode[0]) |=>
        module_capture_value[7:0] == $past(sfr_wdata)) else $error("low byte");
    reload_path_a: assert property (w2 && pwm_wide_mode[2] |=>
        auto_reload_value[47:40] == $past(sfr_wdata) && $stable(module_capture_value[47:40]))
        else $error("reload path");
    cover property (rl ##2 rh);
    cover property (wc && !watchdog_enable_bit);
    cover property (w2 && pwm_wide_mode[2]);
endmodule
bind counter_array_capture_regs counter_array_capture_regs_monitor i_monitor (
    .clk                  (clk),
    .srst                 (srst),
    .sfr_addr             (sfr_addr),
    .sfr_wdata            (sfr_wdata),
    .sfr_wr               (sfr_wr),
    .sfr_rd               (sfr_rd),
    .sfr_rdata            (sfr_rdata),
    .array_counter        (array_counter),
    .watchdog_enable_bit  (watchdog_enable_bit),
    .auto_reload_select   (auto_reload_select),
    .pwm_wide_mode        (pwm_wide_mode),
    .counter_low_wr       (counter_low_wr),
    .counter_high_wr      (counter_high_wr),
    .counter_wdata        (counter_wdata),
    .module_capture_value (module_capture_value),
    .auto_reload_value    (auto_reload_value),
    .comparator_enable    (comparator_enable)
);
`default_nettype wire

// [tb_top.sv]
// Random bench with corner cases for the counter array register block.
// Assumes package, design and monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 0, srst = 1, sfr_wr = 0, sfr_rd = 0, watchdog_enable_bit = 0;
    logic        auto_reload_select = 0, counter_low_wr, counter_high_wr;
    logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata, counter_wdata, e;
    logic [15:0] array_counter = 0, d, mc [3] = '{0, 0, 0}, mr [3] = '{0, 0, 0};
    logic [2:0]  pwm_wide_mode = 0, comparator_enable;
    logic [47:0] module_capture_value, auto_reload_value;
    logic [7:0]  ml [3] = '{counter_array_pkg::module0_low_addr,
                            counter_array_pkg::module1_low_addr,
                            counter_array_pkg::module2_low_addr};
    logic [7:0]  mh [3] = '{counter_array_pkg::module0_high_addr,
                            counter_array_pkg::module1_high_addr,
                            counter_array_pkg::module2_high_addr};
    int          num_errors = 0, compares = 0, seed = 87, n;
    counter_array_capture_regs i_counter_array_capture_regs (
        .clk                  (clk),
        .srst                 (srst),
        .sfr_addr             (sfr_addr),
        .sfr_wdata            (sfr_wdata),
        .sfr_wr               (sfr_wr),
        .sfr_rd               (sfr_rd),
        .sfr_rdata            (sfr_rdata),
        .array_counter        (array_counter),
        .watchdog_enable_bit  (watchdog_enable_bit),
        .auto_reload_select   (auto_reload_select),
        .pwm_wide_mode        (pwm_wide_mode),
        .counter_low_wr       (counter_low_wr),
        .counter_high_wr      (counter_high_wr),
        .counter_wdata        (counter_wdata),
        .module_capture_value (module_capture_value),
        .auto_reload_value    (auto_reload_value),
        .comparator_enable    (comparator_enable)
    );
    initial forever #50 clk = ~clk;
    task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [7:0] v);
        @(negedge clk);
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, !w, a, v};
        @(negedge clk);
        {sfr_wr, sfr_rd} = 2'b00;
    endtask
    function automatic logic rl(int k);
        return auto_reload_select && pwm_wide_mode[k];
    endfunction
    // Expected byte at a module address, from the values the bench has written.
    function automatic logic [7:0] pick(int k, logic hi);
        logic [15:0] v;
        v = rl(k) ? mr[k] : mc[k];
        return hi ? v[15:8] : v[7:0];
    endfunction
    task automatic results();
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        results();
    end
    initial begin
        repeat (6) @(negedge clk);
        srst = 0;
        // Reset reads, starting at an unmapped address below the counter.
        for (int a = 8'hf8; a < 8'hfd; a++) begin
            acc(0, 8'(a), 0);
            chk("reset read", 0, sfr_rdata);
        end
        for (int i = 0; i < 60; i++) begin
            n = i % 3;
            {auto_reload_select, pwm_wide_mode} = 4'($random(seed));
            d = 16'($random(seed));
            acc(1, ml[n], d[7:0]);
            chk("enable low", 0, comparator_enable[n]);
            acc(1, mh[n], d[15:8]);
            chk("enable high", 1, comparator_enable[n]);
            if (rl(n)) mr[n] = d;
            else mc[n] = d;
            chk("capture", mc[n], module_capture_value[16*n +: 16]);
            chk("reload", mr[n], auto_reload_value[16*n +: 16]);
            acc(0, ml[n], 0);
            chk("read low", pick(n, 1'h0), sfr_rdata);
            acc(0, mh[n], 0);
            chk("read back", pick(n, 1'h1), sfr_rdata);
        end
        for (int i = 0; i < 40; i++) begin
            array_counter = 16'($random(seed));
            d = 16'($random(seed));
            acc(0, counter_array_pkg::counter_low_addr, 0);
            chk("counter low", array_counter[7:0], sfr_rdata);
            e = array_counter[15:8];
            array_counter = d;
            acc(0, counter_array_pkg::counter_high_addr, 0);
            chk("snapshot", e, sfr_rdata);
            watchdog_enable_bit = d[0];
            acc(1, d[1] ? counter_array_pkg::counter_high_addr
                        : counter_array_pkg::counter_low_addr, d[15:8]);
            chk("strobe", d[0] ? 0 : d[1] + 1, {counter_high_wr, counter_low_wr});
            if (!d[0]) chk("write data", d[15:8], counter_wdata);
        end
        // Mid-run reset: stored values, enables and the snapshot return to zero.
        @(negedge clk);
        srst = 1;
        repeat (2) @(negedge clk);
        srst = 0;
        chk("reset values", 0, module_capture_value | auto_reload_value);
        chk("reset enable", 0, comparator_enable);
        acc(0, counter_array_pkg::counter_high_addr, 0);
        chk("reset snapshot", 0, sfr_rdata);
        results();
    end
endmodule
`default_nettype wire
